/* inc/spt_pkg.sv */
// Package of constants and types for the single channel PWM timer.
package spt_pkg;

  // ----------------------------------------------------------------
  // Widths and rates
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned COUNT_HZ    = 20_000_000;
  localparam int unsigned ACC_W       = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PERIOD   = 8'h04;
  localparam logic [7:0] OFS_RISE     = 8'h08;
  localparam logic [7:0] OFS_FALL     = 8'h0c;
  localparam logic [7:0] OFS_COUNT    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_MASK     = 8'h18;
  localparam logic [7:0] OFS_PIN      = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned EVT_PER_BIT  = 0;
  localparam int unsigned EVT_RISE_BIT = 1;
  localparam int unsigned EVT_FALL_BIT = 2;
  localparam int unsigned EVT_W        = 3;
  localparam logic [CNT_W-1:0] RST_PERIOD = 16'h0f9f;
  localparam logic [CNT_W-1:0] RST_RISE   = 16'h03e8;
  localparam logic [CNT_W-1:0] RST_FALL   = 16'h0bb8;
  localparam logic [EVT_W-1:0] RST_MASK   = 3'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] rise;
    logic [CNT_W-1:0] fall;
  } spt_cmp_t;

endpackage

/* core/spt_timer.sv */
// Single channel PWM timer with an AXI4-Lite register slave.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] Counter advances once per undivided count clock tick, each count one tick.
// [R2] Counter equal to period compare clears it to zero, starting next cycle.
// [R3] PWM period is period compare plus one count ticks.
// [R4] Counter equal to rise compare drives the PWM pin high.
// [R5] Counter equal to fall compare drives the PWM pin low.
// [R6] Pin starts low after setup, stays low until rise match; active high.
// [R7] High time is fall minus rise counts; wait equals rise counts.
// [R8] Each period match sets the period status bit; it raises the timer interrupt request only while its mask bit is set.
// [R9] Software keeps external trigger disabled; only compare matches steer counting.
// [R10] Software writes compare values directly; no buffered compare operation.
// [R11] Counter starts at zero, increments by one, counts only while enabled.
module spt_timer
  import spt_pkg::*;
#(
  parameter int unsigned CLK_RATE   = CLK_HZ,
  parameter int unsigned COUNT_RATE = COUNT_HZ
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Pin and interrupt
  output logic             pwm_out_pin_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_PIN);
  endfunction

  function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old,
                                             input logic [31:0]      nw,
                                             input logic [3:0]       be);
    logic [CNT_W-1:0] r;
    r = old;
    for (int i = 0; i < CNT_W / 8; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic             enable_q;
  spt_cmp_t         cmp_q;
  logic [CNT_W-1:0] period_counter_q;
  logic [CNT_W-1:0] period_counter_d;
  logic [ACC_W-1:0] acc_q;
  logic             tick;
  logic             pin_q;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] evt;
  logic             per_match;
  logic             rise_match;
  logic             fall_match;

  logic             aw_held_q;
  logic [7:0]       aw_addr_q;
  logic             w_held_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;
  logic             wr_do;
  logic             rd_do;
  logic             stat_rd;
  logic [31:0]      rd_word;

  // ----------------------------------------------------------------
  // Count clock divider
  // ----------------------------------------------------------------
  // A phase accumulator gives an average count rate of exactly COUNT_RATE
  // even though the system clock is not an integer multiple of it.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      acc_q <= '0;
    end else if (acc_q + ACC_W'(COUNT_RATE) >= ACC_W'(CLK_RATE)) begin
      acc_q <= acc_q + ACC_W'(COUNT_RATE) - ACC_W'(CLK_RATE); // [R1]
    end else begin
      acc_q <= acc_q + ACC_W'(COUNT_RATE);
    end
  end

  assign tick = (acc_q + ACC_W'(COUNT_RATE) >= ACC_W'(CLK_RATE)); // [R1]

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  assign per_match  = enable_q && tick && (period_counter_q == cmp_q.period);
  assign rise_match = enable_q && tick && (period_counter_q == cmp_q.rise);
  assign fall_match = enable_q && tick && (period_counter_q == cmp_q.fall);

  always_comb begin
    period_counter_d = period_counter_q;
    if (!enable_q) begin
      period_counter_d = '0; // [R11]
    end else if (per_match) begin
      period_counter_d = '0; // [R2] [R3]
    end else if (tick) begin
      period_counter_d = period_counter_q + CNT_W'(1); // [R11]
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      period_counter_q <= '0;
    end else begin
      period_counter_q <= period_counter_d;
    end
  end

  // ----------------------------------------------------------------
  // PWM output
  // ----------------------------------------------------------------
  // A fall match wins over a rise match at the same count, so equal
  // compare values give a pin that stays low.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pin_q <= 1'b0;
    end else if (!enable_q) begin
      pin_q <= 1'b0; // [R6]
    end else if (fall_match) begin
      pin_q <= 1'b0; // [R5] [R7]
    end else if (rise_match) begin
      pin_q <= 1'b1; // [R4] [R7]
    end
  end

  assign pwm_out_pin_o = pin_q;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  assign evt = {fall_match, rise_match, per_match};

  // A new event in the cycle of the clearing read survives the clear.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= (stat_rd ? '0 : status_q) | evt; // [R8]
    end
  end

  assign irq_o = |(status_q & mask_q); // [R8]

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_do) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_do) begin
      w_held_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_do         = aw_held_q && w_held_q && !bvalid_q;

  // Compare values land straight in the active registers and take effect
  // at the next count; software must avoid writing mid-cycle if it needs
  // glitch-free periods.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      enable_q   <= 1'b0;
      cmp_q      <= '{period: RST_PERIOD, rise: RST_RISE, fall: RST_FALL};
      mask_q     <= RST_MASK;
    end else if (wr_do) begin
      case (aw_addr_q)
        OFS_CTRL: begin
          enable_q <= w_strb_q[0] ? w_data_q[CTRL_EN_BIT] : enable_q; // [R11]
        end
        OFS_PERIOD: begin
          cmp_q.period <= merge(cmp_q.period, w_data_q, w_strb_q); // [R10]
        end
        OFS_RISE: begin
          cmp_q.rise <= merge(cmp_q.rise, w_data_q, w_strb_q); // [R10]
        end
        OFS_FALL: begin
          cmp_q.fall <= merge(cmp_q.fall, w_data_q, w_strb_q); // [R10]
        end
        OFS_MASK: begin
          mask_q <= w_strb_q[0] ? w_data_q[EVT_W-1:0] : mask_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign rd_do         = s_axi_arvalid && s_axi_arready;
  assign stat_rd       = rd_do && (s_axi_araddr == OFS_STATUS);

  always_comb begin
    rd_word = '0;
    case (s_axi_araddr)
      OFS_CTRL:   rd_word = {31'h0, enable_q};
      OFS_PERIOD: rd_word = {16'h0, cmp_q.period};
      OFS_RISE:   rd_word = {16'h0, cmp_q.rise};
      OFS_FALL:   rd_word = {16'h0, cmp_q.fall};
      OFS_COUNT:  rd_word = {16'h0, period_counter_q};
      OFS_STATUS: rd_word = {29'h0, status_q};
      OFS_MASK:   rd_word = {29'h0, mask_q};
      OFS_PIN:    rd_word = {31'h0, pin_q};
      default:    rd_word = '0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_do) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int unsigned gap_q;

  // Cycles since the last count tick, to bound the divider.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || tick) begin
      gap_q <= 0;
    end else begin
      gap_q <= gap_q + 1;
    end
  end

  chk_tick_spacing: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R1]
    gap_q < (CLK_RATE + COUNT_RATE - 1) / COUNT_RATE)
    else $error("count tick came too late");

  chk_period_wrap: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R2]
    per_match |=> (period_counter_q == '0))
    else $error("counter not cleared on period match");

  chk_count_bound: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R3]
    enable_q && !wr_do && (period_counter_q <= cmp_q.period)
    |=> (period_counter_q <= cmp_q.period))
    else $error("counter passed the period value");

  chk_rise_high: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R4]
    rise_match && !fall_match |=> pwm_out_pin_o)
    else $error("pin not high after rise match");

  chk_fall_low: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R5]
    fall_match |=> !pwm_out_pin_o)
    else $error("pin not low after fall match");

  chk_idle_low: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R6]
    !enable_q |=> !pwm_out_pin_o && (period_counter_q == '0))
    else $error("pin or counter active while disabled");

  chk_pin_cause: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R7]
    $rose(pwm_out_pin_o) |-> $past(rise_match))
    else $error("pin rose without rise match");

  chk_irq_set: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R8]
    per_match && mask_q[EVT_PER_BIT] && !wr_do |=> irq_o && status_q[EVT_PER_BIT])
    else $error("period match did not raise interrupt");

  chk_count_step: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R11]
    enable_q && tick && !per_match |=> period_counter_q == $past(period_counter_q) + 16'h1)
    else $error("counter did not step by one");

  chk_hold_notick: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R11]
    enable_q && !tick && !wr_do |=> $stable(period_counter_q))
    else $error("counter moved without tick");

  cov_pwm_cycle: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    rise_match ##[1:1000] fall_match);

  cov_irq: cover property (@(posedge clock_i) disable iff (sys_rst_i) $rose(irq_o));

  cov_status_read: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    stat_rd && (status_q != '0));

  cov_slverr: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    s_axi_rvalid && (s_axi_rresp == RESP_SLVERR));

endmodule

`default_nettype wire

/* tb/spt_load_model.sv */
// Load model on the PWM pin that measures pulse width and period in clocks.
`timescale 1ns/1ps
`default_nettype none
module spt_load_model (
  // Clock and pin
  input  wire logic        clock_i,
  input  wire logic        pin_i,
  // Measurements
  output logic [15:0]      hi_len_o,
  output logic [15:0]      per_len_o,
  output logic [15:0]      rises_o
);
  logic        pin_q     = 1'b0;
  logic [15:0] hi_q      = 16'h0;
  logic [15:0] per_q     = 16'h0;
  logic [15:0] hi_len_q  = 16'h0;
  logic [15:0] per_len_q = 16'h0;
  logic [15:0] rises_q   = 16'h0;

  assign hi_len_o  = hi_len_q;
  assign per_len_o = per_len_q;
  assign rises_o   = rises_q;

  // The pin is a plain input to the load, so nothing is driven back.
  always @(posedge clock_i) begin
    pin_q <= pin_i;
    if (pin_i === 1'b1 && pin_q === 1'b0) begin
      per_len_q <= per_q;
      per_q     <= 16'h1;
      hi_q      <= 16'h1;
      rises_q   <= rises_q + 16'h1;
    end else begin
      per_q <= per_q + 16'h1;
      if (pin_i === 1'b1)
        hi_q <= hi_q + 16'h1;
    end
    if (pin_i === 1'b0 && pin_q === 1'b1)
      hi_len_q <= hi_q;
  end
endmodule
`default_nettype wire

/* tb/single_channel_pwm_timer_tb_top.sv */
// Self-checking testbench of the single channel PWM timer.
`timescale 1ns/1ps
`default_nettype none
module single_channel_pwm_timer_tb_top
  import spt_pkg::*;
;
  logic        clock_i   = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic [7:0]  araddr    = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, pwm, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [15:0] hi_len, per_len, rises, per, ri, fa;
  logic [3:0]  wstrb     = 4'hf;
  logic        pwm_div;
  logic [15:0] hi_div, per_div, rises_div;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          seed        = 32'h6306;

  always #4 clock_i = ~clock_i;

  // One count tick per clock keeps each PWM cycle short.
  spt_timer #(.CLK_RATE(CLK_HZ), .COUNT_RATE(CLK_HZ)) uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pwm_out_pin_o(pwm), .irq_o(irq));

  spt_load_model load (.clock_i(clock_i), .pin_i(pwm), .hi_len_o(hi_len),
    .per_len_o(per_len), .rises_o(rises));

  // A second copy at the real count rate shares the bus and exercises the divider.
  spt_timer uut_div (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(), .s_axi_bready(bready),
    .s_axi_bresp(), .s_axi_arvalid(arvalid), .s_axi_arready(),
    .s_axi_araddr(araddr), .s_axi_rvalid(), .s_axi_rready(rready),
    .s_axi_rdata(), .s_axi_rresp(), .pwm_out_pin_o(pwm_div), .irq_o());

  spt_load_model load_div (.clock_i(clock_i), .pin_i(pwm_div), .hi_len_o(hi_div),
    .per_len_o(per_div), .rises_o(rises_div));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Handshakes are judged at the falling edge, where inputs and outputs are settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic aw_h;
    logic w_h;
    logic b_h;
    logic [1:0] rs;
    b_h = 1'b0;
    @(posedge clock_i);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= v;
    bready  <= 1'b1;
    while (!b_h) begin
      @(negedge clock_i);
      aw_h = awvalid & awready;
      w_h  = wvalid & wready;
      b_h  = bvalid;
      rs   = bresp;
      @(posedge clock_i);
      if (aw_h) awvalid <= 1'b0;
      if (w_h) wvalid <= 1'b0;
      if (b_h) bready <= 1'b0;
    end
    check("bvalid", 1, {31'h0, !awvalid && !wvalid});
    check("bresp", {30'h0, e}, {30'h0, rs});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] e, output logic [31:0] v);
    logic ar_h;
    logic r_h;
    logic [1:0] rs;
    r_h = 1'b0;
    @(posedge clock_i);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!r_h) begin
      @(negedge clock_i);
      ar_h = arvalid & arready;
      r_h  = rvalid;
      v    = rdata;
      rs   = rresp;
      @(posedge clock_i);
      if (ar_h) arvalid <= 1'b0;
      if (r_h) rready <= 1'b0;
    end
    check("rvalid", 1, {31'h0, !arvalid});
    check("rresp", {30'h0, e}, {30'h0, rs});
  endtask

  // Waits for n rising edges of the direct pin, or of the divided copy's pin when div is set.
  task automatic wait_rises(input logic [15:0] n, input logic div);
    logic [15:0] start;
    start = div ? rises_div : rises;
    for (int t = 0; t < 2000 && ((div ? rises_div : rises) - start) < n; t++) begin
      @(posedge clock_i);
    end
    check("rises", 1, ((div ? rises_div : rises) - start) >= n);
  endtask

  // True when a span of clocks matches a span of count ticks to within one count tick (CLK_HZ / COUNT_HZ clocks).
  function automatic logic near_period(input logic [15:0] clocks, input logic [15:0] counts);
    longint diff;
    longint lim;
    lim  = CLK_HZ;
    diff = longint'(clocks) * COUNT_HZ - longint'(counts) * CLK_HZ;
    near_period = (diff < lim) && (diff > -lim);
  endfunction

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    $display("Error watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(OFS_CTRL, RESP_OKAY, d);
    check("ctrl", 0, d);
    rd(OFS_PERIOD, RESP_OKAY, d);
    check("period", {16'h0, RST_PERIOD}, d);
    rd(OFS_RISE, RESP_OKAY, d);
    check("rise", {16'h0, RST_RISE}, d);
    rd(OFS_FALL, RESP_OKAY, d);
    check("fall", {16'h0, RST_FALL}, d);
    rd(OFS_STATUS, RESP_OKAY, d);
    check("status", 0, d);
    rd(8'h20, RESP_SLVERR, d);
    check("unmapped", 0, d);
    wstrb <= 4'h2;
    @(negedge clock_i);
    check("pin_reset", 0, pwm);
    wr(OFS_PERIOD, 32'h0000_ab00, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFS_PERIOD, RESP_OKAY, d);
    check("period_lane", {16'h0, 8'hab, RST_PERIOD[7:0]}, d);
    wr(8'h01, 32'h1, RESP_SLVERR);
    rd(OFS_CTRL, RESP_OKAY, d);
    check("ctrl_unaligned", 0, d);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      per = 16'(12 + ($random(seed) & 31));
      ri  = 16'(1 + ($random(seed) & 7));
      fa  = ri + 16'(1 + ($random(seed) & 3));
      if (i == 0) begin
        per = 16'd9;
        ri  = 16'd0;
        fa  = 16'd9;
      end
      wr(OFS_CTRL, 32'h0, RESP_OKAY);
      wr(OFS_PERIOD, {16'h0, per}, RESP_OKAY);
      wr(OFS_RISE, {16'h0, ri}, RESP_OKAY);
      wr(OFS_FALL, {16'h0, fa}, RESP_OKAY);
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      wait_rises(16'd3, 1'b0);
      check("per_len", {16'h0, per + 16'h1}, {16'h0, per_len});
      check("hi_len", {16'h0, fa - ri}, {16'h0, hi_len});
      wait_rises(16'd3, 1'b1);
      check("per_div", 1, near_period(per_div, per + 16'h1));
      check("hi_div", 1, near_period(hi_div, fa - ri));
      rd(OFS_COUNT, RESP_OKAY, d);
      check("count_range", 1, d <= {16'h0, per});
      $display("test pwm %0d done", i);
    end
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, RESP_OKAY, d);
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    wait_rises(16'd2, 1'b0);
    @(negedge clock_i);
    check("irq_masked", 0, irq);
    wr(OFS_MASK, 32'h1, RESP_OKAY);
    @(negedge clock_i);
    check("irq", 1, irq);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, RESP_OKAY, d);
    check("status_period", 1, d[EVT_PER_BIT]);
    @(negedge clock_i);
    check("irq_clear", 0, irq);
    rd(OFS_STATUS, RESP_OKAY, d);
    check("status_clear", 0, d);
    rd(OFS_COUNT, RESP_OKAY, d);
    check("count_off", 0, d);
    rd(OFS_PIN, RESP_OKAY, d);
    check("pin_off", 0, d);
    $display("test interrupt done");
    conclude();
  end
endmodule
`default_nettype wire
